// ### hdl/dcg_top.sv
// digital clock gating control with part identifier register
//
// Summary of operation
// - Host write of 0x01 to clock-enable register starts the clock.
// - While the clock is off, host writes other than to the clock-enable register are ignored.
// - Once the clock starts, the stored enable value self-clears to zero.
// - A Type-C partner attach starts the clock without host action.
// - Host writing zero to 0x39 stops the digital clock.
// - Enable bit cleared, or supply in undervoltage lockout, stops the clock.
// - Read-only identifier at 0x38 returns a fixed code; writes ignored.
`timescale 1ns/1ps
module dcg_top
    import dcg_pkg::*;
#(
    parameter logic [7:0] PART_ID = PART_ID_DEFAULT
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_partner_attached,
    input wire logic i_enable_bit,
    input wire logic i_undervoltage_lockout,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_rvalid,
    output logic o_clock_on,
    output logic o_write_accept
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        dcg_state_type state;
        logic [DATA_W-1:0] enable_reg;
        logic attach_seen;
        logic rvalid;
    } dcg_top_state_type;

    dcg_top_state_type st;
    dcg_top_state_type next_st;
    logic id_hit;
    logic [DATA_W-1:0] id_rdata;
    logic wr_enable_reg;
    logic attach_rise;
    logic stop_cond;

    dcg_id_reg #(
        .PART_ID(PART_ID)
    ) u_id (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_rd(i_rd),
        .i_addr(i_addr),
        .o_hit(id_hit),
        .o_rdata(id_rdata)
    );

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic clock_running;
    logic addr_is_enable;
    logic wr_start_value;
    logic wr_stop_value;

    assign clock_running = (st.state == DCG_ON);
    assign addr_is_enable = (i_addr == ADDR_DIGITAL_CLOCK_ENABLE);
    // only the exact on and off codes act; other values written to
    // the enable register are dropped
    assign wr_start_value = (i_wdata == CLOCK_ON_VALUE);
    assign wr_stop_value = (i_wdata == CLOCK_OFF_VALUE);
    // the clock-enable register stays writable while off, else the
    // clock could never be started by the host
    assign wr_enable_reg = i_wr && addr_is_enable;

    // ------------------------------------------------------------
    // write gating
    // ------------------------------------------------------------
    // other writes only accepted while clocked
    assign o_write_accept = i_wr && clock_running && !id_hit;

    // ------------------------------------------------------------
    // stop conditions
    // ------------------------------------------------------------
    logic host_stop;
    logic stop_req;

    assign host_stop = wr_enable_reg && wr_stop_value;
    assign stop_cond = !i_enable_bit || i_undervoltage_lockout;
    // lockout is a level, so it keeps the clock down for as long as
    // it lasts
    assign stop_req = host_stop || stop_cond;

    // ------------------------------------------------------------
    // start conditions
    // ------------------------------------------------------------
    logic pins_allow;
    logic host_start;
    logic attach_start;
    logic start_req;

    // a start is refused while the pins hold the clock stopped, so a
    // start and a pin stop never meet in one cycle
    assign pins_allow = !stop_cond;
    assign host_start = wr_enable_reg && wr_start_value && pins_allow;
    // a partner that stays attached must not restart a clock that the
    // host has stopped, so only the rising edge counts
    assign attach_rise = i_partner_attached && !st.attach_seen;
    assign attach_start = attach_rise && pins_allow;
    // a stop write in the same cycle outweighs an attach
    assign start_req = host_start || (attach_start && !host_stop);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.attach_seen = i_partner_attached;
        next_st.rvalid = i_rd;
        if (clock_running) begin
            next_st.enable_reg = ENABLE_RESET;
        end
        case (st.state)
            DCG_OFF: begin
                if (start_req) begin
                    next_st.state = DCG_ON;
                end
                if (host_start) begin
                    next_st.enable_reg = i_wdata;
                end
            end
            DCG_ON: begin
                if (stop_req) begin
                    next_st.state = DCG_OFF;
                end
            end
            default: begin
                next_st.state = DCG_OFF;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st <= '{state: DCG_OFF,
                    enable_reg: ENABLE_RESET,
                    attach_seen: 1'b0,
                    rvalid: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_clock_on = clock_running;
    assign o_rvalid = st.rvalid;
    // reads of any other address, the write-only enable register
    // included, leave the last identifier value on the bus
    assign o_rdata = id_rdata;
endmodule

// ### hdl/dcg_pkg.sv
// constants for the digital clock gate and part identifier block
package dcg_pkg;
    localparam logic [7:0] ADDR_PART_IDENTIFIER = 8'h38;
    localparam logic [7:0] ADDR_DIGITAL_CLOCK_ENABLE = 8'h39;
    localparam logic [7:0] CLOCK_ON_VALUE = 8'h01;
    localparam logic [7:0] CLOCK_OFF_VALUE = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    // arbitrary neutral identification value
    localparam logic [7:0] PART_ID_DEFAULT = 8'h5a;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    typedef enum logic [1:0] {
        DCG_OFF = 2'b00,
        DCG_ON = 2'b01
    } dcg_state_type;
endpackage

// ### hdl/dcg_id_reg.sv
// read-only part identifier register
`timescale 1ns/1ps
module dcg_id_reg
    import dcg_pkg::*;
#(
    parameter logic [7:0] PART_ID = PART_ID_DEFAULT
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_rd,
    input wire logic [ADDR_W-1:0] i_addr,
    output logic o_hit,
    output logic [DATA_W-1:0] o_rdata
);
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
    } dcg_id_state_type;

    dcg_id_state_type st;
    dcg_id_state_type next_st;

    // fixed id, writes never reach it
    assign o_hit = (i_addr == ADDR_PART_IDENTIFIER);

    always_comb begin
        next_st = st;
        if (i_rd && o_hit) begin
            next_st.rdata = PART_ID;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st <= '{rdata: RDATA_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
endmodule

// ### bench/dcg_asserts.sv
// port assertions for the clock gate and identifier
`timescale 1ns/1ps
module dcg_asserts
    import dcg_pkg::*;
#(parameter logic [7:0] PART_ID = PART_ID_DEFAULT) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_partner_attached,
    input wire logic i_enable_bit,
    input wire logic i_undervoltage_lockout,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_clock_on,
    input wire logic o_write_accept
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    wire logic go = i_enable_bit && !i_undervoltage_lockout;
    wire logic clk_wr = i_wr && i_addr == ADDR_DIGITAL_CLOCK_ENABLE;
    a_id_read:
    assert property (i_rd && i_addr == ADDR_PART_IDENTIFIER |=>
        o_rvalid && o_rdata == PART_ID) else $error("id read wrong");
    a_rvalid_cause:
    assert property (!i_rd |=> !o_rvalid) else $error("stray rvalid");
    a_host_start:
    assert property (clk_wr && i_wdata == CLOCK_ON_VALUE && go |=> o_clock_on)
        else $error("clock did not start");
    a_host_stop:
    assert property (clk_wr && i_wdata == CLOCK_OFF_VALUE |=> !o_clock_on)
        else $error("clock did not stop");
    a_attach_start:
    assert property ($rose(i_partner_attached) && go
        && !(clk_wr && i_wdata == CLOCK_OFF_VALUE) |=> o_clock_on)
        else $error("attach did not start clock");
    a_lockout_stop:
    assert property (!go |=> !o_clock_on) else $error("clock ran in lockout");
    a_off_refuse:
    assert property (!o_clock_on && i_wr && !clk_wr |-> !o_write_accept)
        else $error("write accepted while off");
    a_accept_on:
    assert property (o_clock_on && i_wr && i_addr != ADDR_PART_IDENTIFIER
        |-> o_write_accept) else $error("write refused while on");
    a_id_write:
    assert property (i_wr && i_addr == ADDR_PART_IDENTIFIER
        |-> !o_write_accept) else $error("id write accepted");
    a_stay_on:
    assert property (o_clock_on && go && !i_wr |=> o_clock_on)
        else $error("clock dropped by itself");
endmodule
bind dcg_top dcg_asserts #(.PART_ID(PART_ID)) u_chk (.*);

// ### bench/dcg_host.sv
// register host model for the clock gate bus
`timescale 1ns/1ps
module dcg_host (
    input wire logic i_clk_sys,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial {o_wr, o_rd, o_addr, o_wdata} = '0;
    task automatic xfer(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge i_clk_sys);
        #1 {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
        @(posedge i_clk_sys);
        // released lines show the inverse, not stale values
        #1 {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
    endtask
endmodule

// ### bench/digital_clock_gate_and_id_test.sv
// self-checking bench for the clock gate and identifier
`timescale 1ns/1ps
module digital_clock_gate_and_id_test;
    import dcg_pkg::*;
    logic clk = 0, rst = 1, att = 0, en = 0, uvl = 0;
    logic wr, rd, rv, con, wacc;
    logic [7:0] addr, wd, rdat;
    logic [7:0] expq[$];
    logic accq[$];
    int n_mismatch = 0, checks_done = 0;
    always #25 clk = ~clk;
    dcg_host h (.i_clk_sys(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wd));
    dcg_top dut (.i_clk_sys(clk), .i_rst(rst), .i_wr(wr), .i_rd(rd),
        .i_addr(addr), .i_wdata(wd), .i_partner_attached(att),
        .i_enable_bit(en), .i_undervoltage_lockout(uvl), .o_rdata(rdat),
        .o_rvalid(rv), .o_clock_on(con), .o_write_accept(wacc));
    task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic clk_is(logic v);
        cmp("clock_on", {7'h0, v}, {7'h0, con});
    endtask
    task automatic acc_is(logic e);
        cmp("write_accept", {7'h0, e}, {7'h0, wacc});
    endtask
    task automatic put(logic [7:0] a, logic [7:0] d, logic acc);
        accq.push_back(acc);
        h.xfer(1'b1, a, d);
    endtask
    task automatic pins(logic a, logic e, logic u);
        @(posedge clk);
        #1 {att, en, uvl} = {a, e, u};
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(negedge clk) begin
        if (rv === 1'b1 && expq.size() > 0) begin
            cmp("rdata", expq.pop_front(), rdat);
        end else if (rv === 1'b1) begin
            n_mismatch++;
            $display("Error rdata expected none seen %h", rdat);
        end
        if (wr === 1'b1 && accq.size() > 0) begin
            acc_is(accq.pop_front());
        end else if (wr === 1'b1) begin
            n_mismatch++;
            $display("Error write_accept expected none seen %b", wacc);
        end
    end
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(92));
        repeat (4) @(posedge clk);
        #1 rst = 0;
        put(ADDR_PART_IDENTIFIER, 8'($urandom), 1'b0);
        put(8'h20, 8'($urandom), 1'b0);
        expq.push_back(PART_ID_DEFAULT);
        h.xfer(1'b0, ADDR_PART_IDENTIFIER, 8'h00);
        clk_is(1'b0);
        put(ADDR_DIGITAL_CLOCK_ENABLE, CLOCK_ON_VALUE, 1'b0);
        clk_is(1'b0);
        pins(1'b0, 1'b1, 1'b0);
        put(ADDR_DIGITAL_CLOCK_ENABLE, CLOCK_ON_VALUE, 1'b0);
        clk_is(1'b1);
        put(8'h20, 8'($urandom), 1'b1);
        put(ADDR_PART_IDENTIFIER, 8'($urandom), 1'b0);
        expq.push_back(PART_ID_DEFAULT);
        h.xfer(1'b0, ADDR_PART_IDENTIFIER, 8'h00);
        repeat (3) @(posedge clk);
        #1 clk_is(1'b1);
        put(ADDR_DIGITAL_CLOCK_ENABLE, CLOCK_OFF_VALUE, 1'b1);
        clk_is(1'b0);
        pins(1'b1, 1'b1, 1'b0);
        @(posedge clk);
        #1 clk_is(1'b1);
        pins(1'b1, 1'b1, 1'b1);
        @(posedge clk);
        #1 clk_is(1'b0);
        pins(1'b0, 1'b1, 1'b0);
        pins(1'b1, 1'b1, 1'b0);
        pins(1'b1, 1'b0, 1'b0);
        @(posedge clk);
        #1 clk_is(1'b0);
        repeat (6) begin
            expq.push_back(PART_ID_DEFAULT);
            h.xfer(1'b0, ($urandom % 2) ? ADDR_PART_IDENTIFIER : 8'($urandom),
                8'h00);
        end
        repeat (2) @(posedge clk);
        if (expq.size() + accq.size() != 0) begin
            n_mismatch++;
            $display("Error queues expected 0 seen %0d",
                expq.size() + accq.size());
        end
        tally_and_finish();
    end
endmodule
